// File: msp_pkg.sv
// Constants and types shared by the multidrop serial port
package msp_pkg;
  // Clock and oversampling
  localparam int CLK_HZ_DEF = 100_000_000;
  localparam int OVS        = 16;
  // Selectable bit rates, in bits per second
  localparam int BAUD_300   = 300;
  localparam int BAUD_600   = 600;
  localparam int BAUD_1200  = 1200;
  localparam int BAUD_2400  = 2400;
  localparam int BAUD_4800  = 4800;
  localparam int BAUD_9600  = 9600;
  localparam logic [2:0] BSEL_300  = 3'h0;
  localparam logic [2:0] BSEL_600  = 3'h1;
  localparam logic [2:0] BSEL_1200 = 3'h2;
  localparam logic [2:0] BSEL_2400 = 3'h3;
  localparam logic [2:0] BSEL_4800 = 3'h4;
  // Character framing
  localparam int DATA_BITS  = 7;
  localparam int BUF_DEPTH  = 80;
  localparam int MAX_UNITS  = 15;
  // Characters of the addressing and request protocol
  localparam logic [6:0] CH_D   = 7'h44;
  localparam logic [6:0] CH_SP  = 7'h20;
  localparam logic [6:0] CH_CR  = 7'h0D;
  localparam logic [6:0] CH_LF  = 7'h0A;
  localparam logic [6:0] CH_BS  = 7'h08;
  localparam logic [6:0] CH_0   = 7'h30;
  localparam logic [6:0] CH_9   = 7'h39;
  // Register indexes on the local register port
  localparam logic [3:0] A_CFG     = 4'h0;
  localparam logic [3:0] A_STATUS  = 4'h1;
  localparam logic [3:0] A_RXIDX   = 4'h2;
  localparam logic [3:0] A_RXDATA  = 4'h3;
  localparam logic [3:0] A_TXDATA  = 4'h4;
  localparam logic [3:0] A_RVAL    = 4'h5;
  localparam logic [3:0] A_RCMD    = 4'h6;
  localparam logic [3:0] A_PRESET  = 4'h7;
  localparam logic [3:0] A_PREWARN = 4'h8;
  localparam logic [3:0] A_KFACTOR = 4'h9;
  localparam logic [3:0] A_CTRL    = 4'hA;
  // Field positions
  localparam int CFG_BAUD_LSB = 0;
  localparam int CFG_PAR_LSB  = 3;
  localparam int CFG_UNIT_LSB = 5;
  localparam int TX_CRLF_BIT  = 8;
  localparam int CTRL_OFFLINE = 0;
  localparam int CTRL_REQCLR  = 1;
  localparam int CTRL_FLAGCLR = 2;
  localparam logic [15:0] CFG_RESET = 16'h0005;
  // Parity modes
  typedef enum logic [1:0] {
    MSP_PAR_ODD   = 2'h0,
    MSP_PAR_EVEN  = 2'h1,
    MSP_PAR_MARK  = 2'h2,
    MSP_PAR_SPACE = 2'h3
  } msp_par_e;
  // Classes of a parameter change asked for over the link
  typedef enum logic [1:0] {
    MSP_RC_PRESET  = 2'h0,
    MSP_RC_PREWARN = 2'h1,
    MSP_RC_KFACTOR = 2'h2,
    MSP_RC_OTHER   = 2'h3
  } msp_rcls_e;
endpackage

// File: msp_tx.sv
// Character transmitter: start, seven data bits, parity, stop
`timescale 1ns/10ps
module msp_tx (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // Timing and character
  input  wire logic       tick16,
  input  wire logic       start,
  input  wire logic [6:0] chr,
  input  wire logic [1:0] par_mode,
  // Line side
  output logic            busy,
  output logic            line_q
);
  typedef enum logic [2:0] {
    MSP_TX_IDLE  = 3'h0,
    MSP_TX_START = 3'h1,
    MSP_TX_DATA  = 3'h3,
    MSP_TX_PAR   = 3'h2,
    MSP_TX_STOP  = 3'h6
  } msp_tx_e;

  msp_tx_e    st_q;
  logic [3:0] sub_q;
  logic [2:0] bit_q;
  logic [6:0] sh_q;
  logic       par_q;
  logic       bit_end;

  assign bit_end = tick16 && (sub_q == 4'(msp_pkg::OVS - 1));
  assign busy    = (st_q != MSP_TX_IDLE);

  // Sequencer; parity follows the data bits, ahead of the stop bit
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_q   <= MSP_TX_IDLE;
      sub_q  <= 4'h0;
      bit_q  <= 3'h0;
      sh_q   <= 7'h00;
      par_q  <= 1'b1;
      line_q <= 1'b1;
    end else begin
      if (tick16 && busy) begin
        sub_q <= sub_q + 4'h1;
      end
      unique case (st_q)
        MSP_TX_IDLE: begin
          line_q <= 1'b1;
          if (start) begin
            sh_q  <= chr;
            sub_q <= 4'h0;
            unique case (par_mode)
              msp_pkg::MSP_PAR_ODD:   par_q <= ~^chr;
              msp_pkg::MSP_PAR_EVEN:  par_q <= ^chr;
              msp_pkg::MSP_PAR_MARK:  par_q <= 1'b1;
              msp_pkg::MSP_PAR_SPACE: par_q <= 1'b0;
            endcase
            line_q <= 1'b0;
            st_q   <= MSP_TX_START;
          end
        end
        MSP_TX_START: begin
          if (bit_end) begin
            line_q <= sh_q[0];
            sh_q   <= {1'b0, sh_q[6:1]};
            bit_q  <= 3'h0;
            st_q   <= MSP_TX_DATA;
          end
        end
        MSP_TX_DATA: begin
          if (bit_end) begin
            if (bit_q == 3'(msp_pkg::DATA_BITS - 1)) begin
              line_q <= par_q;
              st_q   <= MSP_TX_PAR;
            end else begin
              line_q <= sh_q[0];
              sh_q   <= {1'b0, sh_q[6:1]};
              bit_q  <= bit_q + 3'h1;
            end
          end
        end
        MSP_TX_PAR: begin
          if (bit_end) begin
            line_q <= 1'b1;
            st_q   <= MSP_TX_STOP;
          end
        end
        MSP_TX_STOP: begin
          if (bit_end) begin
            st_q <= MSP_TX_IDLE;
          end
        end
        default: st_q <= MSP_TX_IDLE;
      endcase
    end
  end
endmodule

// File: msp_port.sv
// Multidrop serial port: addressing, echo, request buffer, replies
//
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
module msp_port #(
  parameter int CLK_HZ = msp_pkg::CLK_HZ_DEF
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Local register port
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [15:0]      rdata_q,
  // Serial link
  input  wire logic        rxd,
  input  wire logic        strobe,
  output logic             txd,
  output logic             txd_oe_q,
  // Local status towards the controller
  output logic             req_ready_q,
  output logic             online_q
);
  ////////////////////////////////////////////////////////////////////////
  // Bit-rate divider
  localparam int DIV300  = CLK_HZ / (msp_pkg::BAUD_300 * msp_pkg::OVS);
  localparam int DIV600  = CLK_HZ / (msp_pkg::BAUD_600 * msp_pkg::OVS);
  localparam int DIV1200 = CLK_HZ / (msp_pkg::BAUD_1200 * msp_pkg::OVS);
  localparam int DIV2400 = CLK_HZ / (msp_pkg::BAUD_2400 * msp_pkg::OVS);
  localparam int DIV4800 = CLK_HZ / (msp_pkg::BAUD_4800 * msp_pkg::OVS);
  localparam int DIV9600 = CLK_HZ / (msp_pkg::BAUD_9600 * msp_pkg::OVS);

  logic [15:0] cfg_q;
  logic [2:0]  baud_sel;
  logic [1:0]  par_mode;
  logic [3:0]  unit_code;
  logic [15:0] div_lim;
  logic [15:0] div_q;
  logic        tick16;

  assign baud_sel  = cfg_q[msp_pkg::CFG_BAUD_LSB +: 3];
  assign par_mode  = cfg_q[msp_pkg::CFG_PAR_LSB +: 2];
  assign unit_code = cfg_q[msp_pkg::CFG_UNIT_LSB +: 4];
  assign tick16    = (div_q >= div_lim); // Rate rise must not wrap

  // Rate select; codes above the last rate fall back to the fastest
  always_comb begin
    unique case (baud_sel)
      msp_pkg::BSEL_300:  div_lim = 16'(DIV300 - 1);
      msp_pkg::BSEL_600:  div_lim = 16'(DIV600 - 1);
      msp_pkg::BSEL_1200: div_lim = 16'(DIV1200 - 1);
      msp_pkg::BSEL_2400: div_lim = 16'(DIV2400 - 1);
      msp_pkg::BSEL_4800: div_lim = 16'(DIV4800 - 1);
      default:            div_lim = 16'(DIV9600 - 1);
    endcase
  end

  // Oversampling tick counter
  always_ff @(posedge mclk) begin
    if (!rst_n || tick16) begin
      div_q <= 16'h0000;
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Strobe synchroniser and edge detect
  logic strb_m_q, strb_s_q, strb_d_q, strb_rise;

  // Only the second and third stages feed the edge detector
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      strb_m_q <= 1'b0;
      strb_s_q <= 1'b0;
      strb_d_q <= 1'b0;
    end else begin
      strb_m_q <= strobe;
      strb_s_q <= strb_m_q;
      strb_d_q <= strb_s_q;
    end
  end
  assign strb_rise = strb_s_q && !strb_d_q;

  ////////////////////////////////////////////////////////////////////////
  // Receiver: parity bit is sampled but never checked
  typedef enum logic [1:0] {
    MSP_RX_IDLE  = 2'h0,
    MSP_RX_START = 2'h1,
    MSP_RX_BITS  = 2'h3,
    MSP_RX_STOP  = 2'h2
  } msp_rx_e;

  msp_rx_e    rx_st_q;
  logic [3:0] rx_sub_q;
  logic [3:0] rx_bit_q;
  logic [7:0] rx_sh_q;
  logic       rx_done_q;
  logic [6:0] rx_chr_q;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rx_st_q   <= MSP_RX_IDLE;
      rx_sub_q  <= 4'h0;
      rx_bit_q  <= 4'h0;
      rx_sh_q   <= 8'h00;
      rx_done_q <= 1'b0;
      rx_chr_q  <= 7'h00;
    end else begin
      rx_done_q <= 1'b0;
      if (tick16) begin
        rx_sub_q <= rx_sub_q + 4'h1;
        unique case (rx_st_q)
          MSP_RX_IDLE: begin
            rx_sub_q <= 4'h0;
            if (!rxd) begin
              rx_st_q <= MSP_RX_START;
            end
          end
          MSP_RX_START: begin
            // Mid-bit check rejects glitches on the idle line
            if (rx_sub_q == 4'(msp_pkg::OVS / 2 - 1)) begin
              rx_sub_q <= 4'h0;
              rx_bit_q <= 4'h0;
              rx_st_q  <= rxd ? MSP_RX_IDLE : MSP_RX_BITS;
            end
          end
          MSP_RX_BITS: begin
            if (rx_sub_q == 4'(msp_pkg::OVS - 1)) begin
              rx_sh_q  <= {rxd, rx_sh_q[7:1]};
              rx_bit_q <= rx_bit_q + 4'h1;
              if (rx_bit_q == 4'(msp_pkg::DATA_BITS)) begin
                rx_st_q <= MSP_RX_STOP;
              end
            end
          end
          MSP_RX_STOP: begin
            if (rx_sub_q == 4'(msp_pkg::OVS - 1)) begin
              rx_chr_q  <= rx_sh_q[6:0];
              rx_done_q <= 1'b1;
              rx_st_q   <= MSP_RX_IDLE;
            end
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Addressing: D, decimal code, space
  typedef enum logic [1:0] {
    MSP_AD_IDLE = 2'h0,
    MSP_AD_D    = 2'h1,
    MSP_AD_NUM  = 2'h3
  } msp_ad_e;

  msp_ad_e    ad_st_q;
  logic [4:0] ad_num_q;
  logic       is_digit;
  logic       addr_hit;
  logic       go_offline;
  logic       addr_evt_q;

  assign is_digit = (rx_chr_q >= msp_pkg::CH_0) && (rx_chr_q <= msp_pkg::CH_9);
  assign addr_hit = rx_done_q && (ad_st_q == MSP_AD_NUM)
                    && (rx_chr_q == msp_pkg::CH_SP)
                    && (ad_num_q == {1'b0, unit_code})
                    && (unit_code != 4'h0);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ad_st_q  <= MSP_AD_IDLE;
      ad_num_q <= 5'h00;
    end else if (rx_done_q) begin
      unique case (ad_st_q)
        MSP_AD_IDLE: begin
          if (rx_chr_q == msp_pkg::CH_D) begin
            ad_st_q  <= MSP_AD_D;
            ad_num_q <= 5'h00;
          end
        end
        MSP_AD_D, MSP_AD_NUM: begin
          if (is_digit && ad_num_q < 5'(msp_pkg::MAX_UNITS)) begin
            ad_num_q <= 5'(ad_num_q * 10 + 5'(rx_chr_q - msp_pkg::CH_0));
            ad_st_q  <= MSP_AD_NUM;
          end else if (rx_chr_q == msp_pkg::CH_D) begin
            ad_st_q  <= MSP_AD_D;
            ad_num_q <= 5'h00;
          end else begin
            ad_st_q <= MSP_AD_IDLE;
          end
        end
        default: ad_st_q <= MSP_AD_IDLE;
      endcase
    end
  end

  // On-line state; code zero keeps the unit permanently on line
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      online_q   <= 1'b0;
      addr_evt_q <= 1'b0;
    end else begin
      if (unit_code == 4'h0) begin
        online_q <= 1'b1;
      end else if (addr_hit || strb_rise) begin
        online_q <= 1'b1;
      end else if (go_offline) begin
        online_q <= 1'b0;
      end
      // Sticky event tells firmware to send its greeting; set wins
      if (addr_hit || strb_rise) begin
        addr_evt_q <= 1'b1;
      end else if (wr && addr == msp_pkg::A_CTRL
                   && wdata[msp_pkg::CTRL_FLAGCLR]) begin
        addr_evt_q <= 1'b0;
      end
    end
  end

  // Driver enable follows the on-line state from a flop
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      txd_oe_q <= 1'b0;
    end else begin
      txd_oe_q <= (unit_code == 4'h0) || online_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Request buffer with backspace editing
  logic [6:0] buf_q [msp_pkg::BUF_DEPTH];
  logic [6:0] cnt_q;
  logic [6:0] rd_idx_q;
  logic       take;

  // Characters heard before the unit went on line are not requests
  assign take = rx_done_q && online_q && !req_ready_q;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cnt_q       <= 7'h00;
      req_ready_q <= 1'b0;
    end else if (take) begin
      if (rx_chr_q == msp_pkg::CH_CR) begin
        req_ready_q <= 1'b1;
      end else if (rx_chr_q == msp_pkg::CH_BS) begin
        if (cnt_q != 7'h00) begin
          cnt_q <= cnt_q - 7'h01;
        end
      end else if (cnt_q < 7'(msp_pkg::BUF_DEPTH)) begin
        buf_q[cnt_q] <= rx_chr_q;
        cnt_q        <= cnt_q + 7'h01;
      end
    end else if ((wr && addr == msp_pkg::A_CTRL
                  && wdata[msp_pkg::CTRL_REQCLR]) || go_offline) begin
      req_ready_q <= 1'b0;
      cnt_q       <= 7'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transmit scheduling: echo first, then firmware replies
  logic       echo_pend_q;
  logic [6:0] echo_chr_q;
  logic       fw_pend_q;
  logic [6:0] fw_chr_q;
  logic [1:0] fw_pre_q;
  logic       tx_busy;
  logic       tx_start;
  logic [6:0] tx_chr;
  logic       echo_go;
  logic       fw_go;

  assign echo_go  = echo_pend_q && !tx_busy;
  assign fw_go    = fw_pend_q && !tx_busy && !echo_pend_q;
  assign tx_start = echo_go || fw_go;

  // Reply prefix walks CR, LF, then the value character
  always_comb begin
    if (echo_pend_q) begin
      tx_chr = echo_chr_q;
    end else if (fw_pre_q == 2'h2) begin
      tx_chr = msp_pkg::CH_CR;
    end else if (fw_pre_q == 2'h1) begin
      tx_chr = msp_pkg::CH_LF;
    end else begin
      tx_chr = fw_chr_q;
    end
  end

  // Echo holds one character; a character at the old rate cannot overrun
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      echo_pend_q <= 1'b0;
      echo_chr_q  <= 7'h00;
    end else if (rx_done_q && online_q) begin
      echo_pend_q <= 1'b1;
      echo_chr_q  <= rx_chr_q;
    end else if (echo_go) begin
      echo_pend_q <= 1'b0;
    end
  end

  // Firmware character; a write while pending is ignored
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      fw_pend_q <= 1'b0;
      fw_chr_q  <= 7'h00;
      fw_pre_q  <= 2'h0;
    end else if (wr && addr == msp_pkg::A_TXDATA && !fw_pend_q) begin
      fw_pend_q <= 1'b1;
      fw_chr_q  <= wdata[6:0];
      fw_pre_q  <= wdata[msp_pkg::TX_CRLF_BIT] ? 2'h2 : 2'h0;
    end else if (fw_go) begin
      if (fw_pre_q == 2'h0) begin
        fw_pend_q <= 1'b0;
      end else begin
        fw_pre_q <= fw_pre_q - 2'h1;
      end
    end
  end

  msp_tx u_tx (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .tick16   (tick16),
    .start    (tx_start),
    .chr      (tx_chr),
    .par_mode (par_mode),
    .busy     (tx_busy),
    .line_q   (txd)
  );

  ////////////////////////////////////////////////////////////////////////
  // Settings: link path never reaches the configuration register
  logic [15:0] rval_q;
  logic [15:0] preset_q;
  logic [15:0] prewarn_q;
  logic [15:0] kfac_q;
  logic        refused_q;

  assign go_offline = wr && addr == msp_pkg::A_CTRL
                      && wdata[msp_pkg::CTRL_OFFLINE];

  // Only the local register port writes rate, parity and unit code
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cfg_q <= msp_pkg::CFG_RESET;
    end else if (wr && addr == msp_pkg::A_CFG) begin
      cfg_q <= wdata;
    end
  end

  // Link-sourced changes pass only for preset, prewarn and K-factor
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rval_q    <= 16'h0000;
      preset_q  <= 16'h0000;
      prewarn_q <= 16'h0000;
      kfac_q    <= 16'h0001;
      refused_q <= 1'b0;
    end else begin
      if (wr && addr == msp_pkg::A_RVAL) begin
        rval_q <= wdata;
      end
      if (wr && addr == msp_pkg::A_RCMD) begin
        unique case (wdata[1:0])
          msp_pkg::MSP_RC_PRESET:  preset_q  <= rval_q;
          msp_pkg::MSP_RC_PREWARN: prewarn_q <= rval_q;
          msp_pkg::MSP_RC_KFACTOR: kfac_q    <= rval_q;
          msp_pkg::MSP_RC_OTHER:   refused_q <= 1'b1;
        endcase
      end else if (wr && addr == msp_pkg::A_CTRL
                   && wdata[msp_pkg::CTRL_FLAGCLR]) begin
        refused_q <= 1'b0;
      end
    end
  end

  // Buffer read index for firmware
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rd_idx_q <= 7'h00;
    end else if (wr && addr == msp_pkg::A_RXIDX) begin
      rd_idx_q <= wdata[6:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data, valid the cycle after the strobe; unmapped reads zero
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rdata_q <= 16'h0000;
    end else if (rd) begin
      unique case (addr)
        msp_pkg::A_CFG:     rdata_q <= cfg_q;
        msp_pkg::A_STATUS:  rdata_q <= {4'h0, refused_q, addr_evt_q,
                                        tx_busy, fw_pend_q, req_ready_q,
                                        cnt_q};
        msp_pkg::A_RXIDX:   rdata_q <= {9'h000, rd_idx_q};
        msp_pkg::A_RXDATA:  rdata_q <= (rd_idx_q < 7'(msp_pkg::BUF_DEPTH))
                                       ? {9'h000, buf_q[rd_idx_q]}
                                       : 16'h0000;
        msp_pkg::A_RVAL:    rdata_q <= rval_q;
        msp_pkg::A_PRESET:  rdata_q <= preset_q;
        msp_pkg::A_PREWARN: rdata_q <= prewarn_q;
        msp_pkg::A_KFACTOR: rdata_q <= kfac_q;
        default:            rdata_q <= 16'h0000;
      endcase
    end else begin
      rdata_q <= 16'h0000;
    end
  end
endmodule

// File: msp_port_sva.sv
// Checker for the multidrop serial port, bound to its top module
`timescale 1ns/10ps
module msp_port_chk #(
  parameter int CLK_HZ = 100000000
) (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rst_n,
  // Register port
  input wire logic [3:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [15:0] rdata_q,
  // Link and status
  input wire logic        rxd,
  input wire logic        strobe,
  input wire logic        txd,
  input wire logic        txd_oe_q,
  input wire logic        req_ready_q,
  input wire logic        online_q
);
  logic [15:0] cfg_q;
  logic [2:0]  zcnt_q;
  logic        ctl_w;

  // Control writes, decoded once
  assign ctl_w = wr && addr == msp_pkg::A_CTRL;
  // Shadow of the config word, only the local port may change it
  always_ff @(posedge mclk) begin
    if (!rst_n) cfg_q <= msp_pkg::CFG_RESET;
    else if (wr && addr == msp_pkg::A_CFG) cfg_q <= wdata;
  end
  // Settle time at code zero; restarts on any config write
  always_ff @(posedge mclk) begin
    if (!rst_n || (wr && addr == msp_pkg::A_CFG)) zcnt_q <= 3'h0;
    else if (cfg_q[8:5] == 4'h0 && zcnt_q != 3'h7) zcnt_q <= zcnt_q + 3'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  AST_OE_NEEDS_ONLINE: assert property ($rose(txd_oe_q) |-> online_q)
    else $error("driver enabled while off line");
  AST_START_DRIVEN: assert property ($fell(txd) |-> txd_oe_q)
    else $error("start bit sent with driver off");
  AST_STROBE_ONLINE: assert property ($rose(strobe) |-> ##[1:6] online_q)
    else $error("strobe edge did not bring unit on line");
  AST_CODE_ZERO: assert property (zcnt_q >= 3'h4 |-> online_q && txd_oe_q)
    else $error("code zero unit not driving");
  AST_REQ_ONLINE: assert property ($rose(req_ready_q) |-> online_q)
    else $error("request completed while off line");
  AST_REQ_CLEAR: assert property (ctl_w && wdata[1] |=> !req_ready_q)
    else $error("request flag survived clear");
  AST_OFF_LINE: assert property (ctl_w && wdata[0] && !strobe &&
    cfg_q[8:5] != 4'h0 |=> !online_q ##[0:2] !txd_oe_q)
    else $error("unit stayed on line after release");
  AST_CFG_READBACK: assert property (rd && addr == msp_pkg::A_CFG
    |=> rdata_q[8:0] == cfg_q[8:0])
    else $error("config readback differs");
  AST_RDATA_IDLE: assert property (!$past(rd) |-> rdata_q == 16'h0000)
    else $error("read data outside read slot");

  // Main scenarios
  cover property ($rose(strobe) ##[1:6] $rose(online_q));
  cover property ($rose(req_ready_q));
  cover property ($fell(txd) && cfg_q[4:3] == 2'h2);
endmodule

bind msp_port msp_port_chk #(.CLK_HZ(CLK_HZ)) u_chk (.mclk(mclk),
  .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata_q(rdata_q), .rxd(rxd), .strobe(strobe), .txd(txd),
  .txd_oe_q(txd_oe_q), .req_ready_q(req_ready_q), .online_q(online_q));

// File: msp_term.sv
// Remote terminal model on the serial link
`timescale 1ns/10ps
module msp_term (
  // Clock
  input  wire logic mclk,
  // Serial link
  output logic      rxd,
  input  wire logic txd,
  input  wire logic txd_oe_q
);
  int         bit_cyc;
  logic [8:0] rx_q[$];
  logic       line;

  // A released driver reads as mark through the terminal pull-up
  assign line = txd_oe_q ? txd : 1'h1;
  initial rxd = 1'h1;

  // One character per call, at the rate the bench set; one unit at a time
  task automatic send(input logic [6:0] c, input logic p);
    logic [9:0] f;
    f = {1'h1, p, c, 1'h0};
    for (int i = 0; i < 10; i++) begin
      rxd <= f[i];
      repeat (bit_cyc) @(posedge mclk);
    end
  endtask

  // Mid-bit sampling; stop kept so the bench can see a bad frame
  always begin : rx_proc
    logic [8:0] sh;
    @(posedge mclk);
    if (line === 1'h0) begin
      repeat (bit_cyc / 2) @(posedge mclk);
      for (int i = 0; i < 9; i++) begin
        repeat (bit_cyc) @(posedge mclk);
        sh[i] = line;
      end
      rx_q.push_back(sh);
    end
  end
endmodule

// File: tb.sv
// Self-checking testbench for the multidrop serial port
`timescale 1ns/10ps
module tb;
  // Small clock rate keeps every divisor exact and the run short
  localparam int CLK = 307200;
  logic        mclk, rst_n, wr, rd, rxd, strobe, txd, txd_oe_q;
  logic        req_ready_q, online_q;
  logic [3:0]  addr;
  logic [15:0] wdata, rdata_q, v, st;
  int          n_fail, n_tests;
  int          bd[6] = '{300, 600, 1200, 2400, 4800, 9600};
  logic [6:0]  bf[5] = '{7'h41, 7'h42, 7'h08, 7'h43, 7'h0D};
  logic [6:0]  ad[7] = '{7'h44, 7'h37, 7'h20, 7'h44, 7'h31, 7'h35, 7'h20};

  // Design, terminal and clock
  msp_port #(.CLK_HZ(CLK)) u_dut (.mclk(mclk), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q), .rxd(rxd),
    .strobe(strobe), .txd(txd), .txd_oe_q(txd_oe_q),
    .req_ready_q(req_ready_q), .online_q(online_q));
  msp_term u_term (.mclk(mclk), .rxd(rxd), .txd(txd), .txd_oe_q(txd_oe_q));
  always #5 mclk = ~mclk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    if (n_fail == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Register cycles; an idle edge between calls keeps strobes one cycle
  task automatic wreg(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'h1;
    @(posedge mclk);
    wr    <= 1'h0;
  endtask
  task automatic rreg(input logic [3:0] a, output logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'h1;
    @(posedge mclk);
    rd   <= 1'h0;
    #1 d = rdata_q;
  endtask
  function automatic logic par(input logic [6:0] c, input logic [1:0] m);
    case (m)
      2'h0: par = ~^c;
      2'h1: par = ^c;
      2'h2: par = 1'h1;
      default: par = 1'h0;
    endcase
  endfunction
  // Next character from the terminal, with parity and stop
  task automatic getc(input logic [6:0] c, input logic [1:0] m);
    logic [8:0] r;
    int         n;
    n = 0;
    r = 9'h000;
    while (u_term.rx_q.size() == 0 && n < 40 * u_term.bit_cyc) begin
      @(posedge mclk);
      n++;
    end
    if (u_term.rx_q.size() != 0) r = u_term.rx_q.pop_front();
    chk({7'h00, r}, {7'h00, 1'h1, par(c, m), c});
  endtask
  // Wrong parity on purpose: the receiver must not care
  task automatic echo(input logic [6:0] c, input logic [1:0] m);
    u_term.send(c, ~par(c, m));
    getc(c, m);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog, a good margin over the roughly 53k cycles of tests
  initial begin
    repeat (90000) @(posedge mclk);
    n_fail++;
    close_out();
  end
  // Main sequence
  initial begin
    mclk = 1'h0;
    rst_n = 1'h0;
    addr = 4'h0;
    wdata = 16'h0000;
    wr = 1'h0;
    rd = 1'h0;
    strobe = 1'h0;
    n_fail = 0;
    n_tests = 0;
    u_term.bit_cyc = CLK / 9600;
    repeat (6) @(posedge mclk);
    rst_n <= 1'h1;
    repeat (3) @(posedge mclk);
    #1 chk(16'(online_q), 16'h0001);
    chk(16'(txd_oe_q), 16'h0001);
    chk(16'(txd), 16'h0001);
    rreg(msp_pkg::A_CFG, v);
    chk(v, msp_pkg::CFG_RESET);
    for (int p = 0; p < 4; p++) begin
      wreg(msp_pkg::A_CFG, {7'h00, 4'h0, 2'(p), 3'h5});
      echo(7'h41, 2'(p));
      echo(7'h43, 2'(p));
    end
    wreg(msp_pkg::A_CTRL, 16'h0002);
    foreach (bf[i]) echo(bf[i], 2'h3);
    #1 chk(16'(req_ready_q), 16'h0001);
    rreg(msp_pkg::A_STATUS, st);
    chk(16'(st[7:0]), 16'h0082);
    echo(7'h5A, 2'h3);
    rreg(msp_pkg::A_STATUS, v);
    chk(16'(v[7:0]), 16'h0082);
    for (int i = 0; i < 2; i++) begin
      wreg(msp_pkg::A_RXIDX, 16'(i));
      rreg(msp_pkg::A_RXDATA, v);
      chk(v, i == 0 ? 16'h0041 : 16'h0043);
    end
    wreg(msp_pkg::A_CTRL, 16'h0002);
    #1 chk(16'(req_ready_q), 16'h0000);
    wreg(msp_pkg::A_TXDATA, 16'h0158);
    getc(7'h0D, 2'h3);
    getc(7'h0A, 2'h3);
    getc(7'h58, 2'h3);
    rreg(msp_pkg::A_KFACTOR, v);
    chk(v, 16'h0001);
    for (int i = 0; i < 3; i++) begin
      wreg(msp_pkg::A_RVAL, 16'h1230 + 16'(i));
      wreg(msp_pkg::A_RCMD, 16'(i));
      rreg(msp_pkg::A_PRESET + 4'(i), v);
      chk(v, 16'h1230 + 16'(i));
    end
    wreg(msp_pkg::A_RVAL, 16'h5555);
    wreg(msp_pkg::A_RCMD, 16'h0003);
    rreg(msp_pkg::A_STATUS, st);
    chk(16'(st[11]), 16'h0001);
    rreg(msp_pkg::A_PRESET, v);
    chk(v, 16'h1230);
    // Code 15 off line: wrong code ignored, two-digit code accepted
    wreg(msp_pkg::A_CFG, 16'h01E5);
    wreg(msp_pkg::A_CTRL, 16'h0005);
    repeat (3) @(posedge mclk);
    #1 chk(16'(txd_oe_q), 16'h0000);
    foreach (ad[i]) begin
      u_term.send(ad[i], 1'h0);
      if (ad[i] == 7'h20) begin
        #1 chk(16'(online_q), 16'(i > 2));
      end
    end
    rreg(msp_pkg::A_STATUS, st);
    chk(16'(st[10]), 16'h0001);
    repeat (3200) @(posedge mclk);
    u_term.rx_q.delete();
    // A held strobe must bring the unit on line once only
    wreg(msp_pkg::A_CTRL, 16'h0005);
    strobe <= 1'h1;
    repeat (8) @(posedge mclk);
    #1 chk(16'(online_q), 16'h0001);
    wreg(msp_pkg::A_CTRL, 16'h0001);
    repeat (8) @(posedge mclk);
    #1 chk(16'(online_q), 16'h0000);
    strobe <= 1'h0;
    for (int r = 0; r < 6; r++) begin
      wreg(msp_pkg::A_CFG, {7'h00, 4'h0, 2'h2, 3'(r)});
      u_term.bit_cyc = CLK / bd[r];
      echo(7'h55, 2'h2);
    end
    close_out();
  end
endmodule
